/* pcsd_pkg.sv */
// constants for the phase count strap detector
// Operation
// - detect the strapped maximum phase count at every pin-setting step, the first after power-on included.
// - a sense pin sampled above supply minus 0.5 V marks its phase disabled.
// - latch the maximum count at every pin-setting detection, hold until next.
// - cap phase counts requested by pins or serial registers at the latched maximum.
`default_nettype none
package pcsd_pkg;
	localparam int unsigned PCSD_MAX_PHASES = 8;
	localparam int unsigned PCSD_CNT_W = 4;
	localparam logic [3:0] PCSD_RESET_COUNT = 4'h1;
	localparam logic [3:0] PCSD_MIN_COUNT = 4'h1;
	typedef enum logic [1:0] {PCSD_IDLE, PCSD_SAMPLE, PCSD_DONE} pcsd_state_t;
endpackage
`default_nettype wire

/* pcsd_phase_count_strap_detect.sv */
// phase count strap detector and phase count limiter
`timescale 1ns/1ps
`default_nettype none
module pcsd_phase_count_strap_detect
	import pcsd_pkg::*;
#(
	parameter int unsigned NUM_PHASES = PCSD_MAX_PHASES
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic pin_setting_strobe_i,
	input wire logic [NUM_PHASES-1:0] phase_current_sense_pin_high_i,
	input wire logic [3:0] requested_phase_count_i,
	output logic [3:0] max_phase_count_o,
	output logic [3:0] allowed_phase_count_o,
	output logic detect_done_o,
	output logic strap_fault_o
);
	// four-bit counts and the run logic serve one to eight phases
	if (NUM_PHASES < 1 || NUM_PHASES > PCSD_MAX_PHASES) begin : g_bad_phases
		$error("pcsd: NUM_PHASES must lie in 1..8");
	end

	// detection state, latched maximum and fault flag
	pcsd_state_t state;
	pcsd_state_t next_state;
	logic [3:0] max_count;
	logic [3:0] next_max_count;
	logic fault;
	logic next_fault;
	// limiter register
	logic [3:0] allowed;
	logic [3:0] next_allowed;
	logic [3:0] strap_count;
	logic [NUM_PHASES:0] run;

	// contiguous run of enabled phases from phase one
	assign run[0] = 1'b1;
	genvar g;
	generate
		for (g = 0; g < NUM_PHASES; g++) begin : g_run
			// pin above supply minus 0.5 V reads high: phase disabled
			assign run[g+1] = run[g] & ~phase_current_sense_pin_high_i[g];
		end
	endgenerate

	// index of the last phase in the run
	always_comb begin
		strap_count = 4'h0;
		for (int i = 1; i <= NUM_PHASES; i++) begin
			if (run[i]) begin
				strap_count = 4'(i);
			end
		end
	end

	// one sample cycle per strobe, then hold the result
	always_comb begin
		next_state = state;
		next_max_count = max_count;
		next_fault = fault;
		unique case (state)
			PCSD_IDLE: begin
				// nothing sensed before the first pin-setting step
				if (pin_setting_strobe_i) begin
					next_state = PCSD_SAMPLE;
				end
			end
			PCSD_SAMPLE: begin
				// first pin tied high is a board error; keep one phase
				if (strap_count < PCSD_MIN_COUNT) begin
					next_max_count = PCSD_MIN_COUNT;
					next_fault = 1'b1;
				end else begin
					next_max_count = strap_count;
					next_fault = 1'b0;
				end
				next_state = PCSD_DONE;
			end
			PCSD_DONE: begin
				// a later pin-setting step detects again
				if (pin_setting_strobe_i) begin
					next_state = PCSD_SAMPLE;
				end
			end
		endcase
	end

	always_comb begin
		// hardware maximum has top priority over any request
		if (requested_phase_count_i > max_count) begin
			next_allowed = max_count;
		// zero asks for no phase; one always runs
		end else if (requested_phase_count_i < PCSD_MIN_COUNT) begin
			next_allowed = PCSD_MIN_COUNT;
		end else begin
			next_allowed = requested_phase_count_i;
		end
	end

	// registers only; reset leaves a one-phase limit
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= PCSD_IDLE;
			max_count <= PCSD_RESET_COUNT;
			fault <= 1'b0;
			allowed <= PCSD_RESET_COUNT;
		end else begin
			state <= next_state;
			max_count <= next_max_count;
			fault <= next_fault;
			allowed <= next_allowed;
		end
	end

	// done is decoded from state; the rest are registers
	assign max_phase_count_o = max_count;
	assign allowed_phase_count_o = allowed;
	assign detect_done_o = (state == PCSD_DONE);
	assign strap_fault_o = fault;

	// limiter: one register stage, so allowed lags a new maximum by a cycle
	a_cap_holds: assert property (@(posedge clock_i) disable iff (!resetn_i)
		allowed <= max_count || $changed(max_count))
		else $error("allowed count above hardware maximum");
	a_cap_follow: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(requested_phase_count_i >= PCSD_MIN_COUNT && requested_phase_count_i <= max_count)
		|=> allowed == $past(requested_phase_count_i))
		else $error("request within limit not passed");
	// requests above the strapped maximum are clipped, never refused
	a_cap_clip: assert property (@(posedge clock_i) disable iff (!resetn_i)
		requested_phase_count_i > max_count |=> allowed == $past(max_count))
		else $error("request above limit not clipped");
	// a zero request still runs one phase
	a_cap_floor: assert property (@(posedge clock_i) disable iff (!resetn_i)
		requested_phase_count_i < PCSD_MIN_COUNT |=> allowed == PCSD_MIN_COUNT)
		else $error("zero request not raised to one phase");
	a_allowed_min: assert property (@(posedge clock_i) disable iff (!resetn_i)
		allowed >= PCSD_MIN_COUNT)
		else $error("allowed count below one phase");
	a_cap_steady: assert property (@(posedge clock_i) disable iff (!resetn_i)
		($stable(requested_phase_count_i) && $stable(max_count)) |=> $stable(allowed))
		else $error("allowed count moved without cause");

	// detection: pins are read only in the sample cycle
	a_latch_sample: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(state == PCSD_SAMPLE && strap_count >= PCSD_MIN_COUNT)
		|=> max_count == $past(strap_count) && detect_done_o)
		else $error("strap count not latched");
	a_latch_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(state != PCSD_SAMPLE) |=> $stable(max_count))
		else $error("maximum changed outside detection");
	a_fault_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(state != PCSD_SAMPLE) |=> $stable(fault))
		else $error("fault flag changed outside detection");
	// a strobe in idle or done starts a new detection
	a_detect_start: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(pin_setting_strobe_i && state != PCSD_SAMPLE)
		|=> state == PCSD_SAMPLE ##1 detect_done_o)
		else $error("detection did not follow strobe");
	a_done_clears: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(detect_done_o && pin_setting_strobe_i) |=> !detect_done_o)
		else $error("done not cleared by new strobe");
	// a strobe that lands in the sample cycle is ignored
	a_sample_once: assert property (@(posedge clock_i) disable iff (!resetn_i)
		state == PCSD_SAMPLE |=> state == PCSD_DONE)
		else $error("sample cycle not followed by done");
	a_done_stays: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(detect_done_o && !pin_setting_strobe_i) |=> detect_done_o)
		else $error("done dropped without strobe");
	// nothing is sensed before the first pin-setting step
	a_idle_waits: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(state == PCSD_IDLE && !pin_setting_strobe_i) |=> state == PCSD_IDLE)
		else $error("detection started without strobe");
	a_idle_max: assert property (@(posedge clock_i) disable iff (!resetn_i)
		state == PCSD_IDLE |-> max_count == PCSD_RESET_COUNT)
		else $error("maximum changed before first detection");
	a_idle_no_fault: assert property (@(posedge clock_i) disable iff (!resetn_i)
		state == PCSD_IDLE |-> !strap_fault_o)
		else $error("fault flag set before first detection");

	// a board that ties the first pin high still gets one phase
	a_first_pin: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(state == PCSD_SAMPLE && phase_current_sense_pin_high_i[0])
		|=> strap_fault_o && max_count == PCSD_MIN_COUNT)
		else $error("first pin high not handled");
	a_fault_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(state == PCSD_SAMPLE && !phase_current_sense_pin_high_i[0]) |=> !strap_fault_o)
		else $error("fault kept with first pin low");
	a_fault_one: assert property (@(posedge clock_i) disable iff (!resetn_i)
		strap_fault_o |-> max_count == PCSD_MIN_COUNT)
		else $error("fault flag without one-phase limit");

	// the count is the length of the run from phase one
	a_count_range: assert property (@(posedge clock_i) disable iff (!resetn_i)
		max_count >= PCSD_MIN_COUNT && max_count <= 4'(NUM_PHASES))
		else $error("maximum count out of range");
	a_all_enabled: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(state == PCSD_SAMPLE && !(|phase_current_sense_pin_high_i))
		|=> max_count == 4'(NUM_PHASES))
		else $error("all phases enabled not counted");

	// pin two only exists when more than one phase is built
	if (NUM_PHASES > 1) begin : g_pin_two
		a_disabled_pin: assert property (@(posedge clock_i) disable iff (!resetn_i)
			(state == PCSD_SAMPLE && phase_current_sense_pin_high_i[1]
				&& !phase_current_sense_pin_high_i[0])
			|=> max_count == 4'h1)
			else $error("pin two high must give one phase");
	end

	// a high pin ends the run; floating pins above it are ignored
	genvar k;
	generate
		for (k = 1; k < NUM_PHASES; k++) begin : g_run_end
			a_run_end: assert property (@(posedge clock_i) disable iff (!resetn_i)
				(state == PCSD_SAMPLE && phase_current_sense_pin_high_i[k]
					&& !(|phase_current_sense_pin_high_i[k-1:0]))
				|=> max_count == 4'(k))
				else $error("run of enabled phases not counted");
		end
	endgenerate
endmodule
`default_nettype wire

/* pcsd_strap_model.sv */
// board strap model on the phase sense pins
`timescale 1ns/1ps
`default_nettype none
module pcsd_strap_model (
	input wire logic [3:0] n_i,
	input wire logic bad_i,
	input wire logic [7:0] noise_i,
	output logic [7:0] pins_o
);
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			pins_o[k] = (k < n_i) ? 1'b0 : (k == n_i) ? 1'b1 : noise_i[k];
		end
		pins_o[0] = pins_o[0] | bad_i;
	end
endmodule
`default_nettype wire

/* phase_count_strap_detect_tb.sv */
// self-checking bench for the phase count strap detector
`timescale 1ns/1ps
`default_nettype none
module phase_count_strap_detect_tb;
	logic clk = 0, rst_n = 0, stb = 0, bad = 0, done, flt;
	logic [3:0] n = 4'h8, req = 4'h0, mx, al, m;
	logic [7:0] pins;
	logic [31:0] lfsr = 32'h79ee48c1;
	int miscompares = 0, n_checks = 0, cyc = 0;
	always #12.5 clk = ~clk;
	pcsd_strap_model board (.n_i(n), .bad_i(bad), .noise_i(lfsr[7:0]), .pins_o(pins));
	pcsd_phase_count_strap_detect DUT (.clock_i(clk), .resetn_i(rst_n),
		.pin_setting_strobe_i(stb), .phase_current_sense_pin_high_i(pins),
		.requested_phase_count_i(req), .max_phase_count_o(mx),
		.allowed_phase_count_o(al), .detect_done_o(done), .strap_fault_o(flt));
	localparam int TIMEOUT_CYCLES = 3000;
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// pin N+1 high gives N phases; first pin high falls back to one
	function automatic logic [3:0] exp_max(input logic [3:0] cnt, input logic first_high);
		return first_high ? 4'h1 : cnt;
	endfunction
	// request clipped to the range one to the latched maximum
	function automatic logic [3:0] exp_allowed(input logic [3:0] r, input logic [3:0] lim);
		if (r == 4'h0) begin
			return 4'h1;
		end
		return (r > lim) ? lim : r;
	endfunction
	task automatic cmp(input string s, input logic [3:0] e, input logic [3:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cmp_flag(input string s, input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %b seen %b", s, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		#1 lfsr = lfsr_next(lfsr);
		cyc++;
		if (cyc == TIMEOUT_CYCLES) begin
			miscompares++;
			report_and_stop();
		end
	end
	// strobe edge moves to sample, the next edge shows the result
	task automatic detect(input logic [3:0] exp_m, input logic exp_f);
		stb = 1;
		@(posedge clk) #1 stb = 0;
		cmp_flag("done in sample", 1'b0, done);
		@(posedge clk) #1;
		cmp_flag("done", 1'b1, done);
		cmp("max", exp_m, mx);
		cmp_flag("fault", exp_f, flt);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 rst_n = 1;
		cmp("allowed", 4'h1, al);
		cmp("max after reset", 4'h1, mx);
		cmp_flag("done after reset", 1'b0, done);
		for (int i = 1; i <= 12; i++) begin
			n = (i <= 8) ? 4'(i) : {1'b0, lfsr[2:0]} + 4'h1;
			bad = (i == 10 || i == 12);
			m = exp_max(n, bad);
			detect(m, bad);
			n = 4'h8 - n;
			for (int j = 0; j < 4; j++) begin
				req = (j == 0) ? 4'hf : (j == 1) ? 4'h0 : lfsr[3:0];
				@(posedge clk) #1;
				cmp("allowed", exp_allowed(req, m), al);
			end
			cmp("held max", m, mx);
		end
		// reset in mid-run brings back the one-phase limit
		rst_n = 0;
		@(posedge clk) #1;
		cmp("max in reset", 4'h1, mx);
		cmp("allowed in reset", 4'h1, al);
		cmp_flag("fault in reset", 1'b0, flt);
		rst_n = 1;
		n = 4'h3;
		bad = 1'b0;
		detect(exp_max(n, bad), bad);
		report_and_stop();
	end
endmodule
`default_nettype wire
